// File: hw/cacc_channel.sv
`include "cacc_consts.svh"
// Function
// - Qualifying pin edge captures counter into register.
// - Rise, fall or both edges chosen by bits.
// - Capture sets event flag; enable raises request.
// - Event flag cleared only by software.
// - Software timer flags sixteen-bit equality.
// - Low write clears, high write sets comparator.
// - High-speed mode toggles pin on match.
// - Frequency mode toggles, adds high to low.
// - Zero half-period behaves as 256 clocks.
// - Frequency mode match enable flags full equality.
// - Eight-bit PWM rises on match, falls overflow.
// - Eight-bit PWM reloads low from high byte.
// - Eight-bit PWM selected by code 00.
// - Narrow PWM match flags rising edge.
// - Eight-bit overflow flag every 256 clocks.
// - Reload select steers the byte accesses.
// - N-bit PWM rises on match, falls overflow.
// - N-bit overflow sets flag and reloads.
// - Overflow every 512, 1024, 2048 clocks.
// - One shared cycle-length setting for PWM; each channel holds its own here.
// - Comparator off forces PWM low, stops toggling.
// - Cycle code 00..11 selects 8..11 bits.
// - Per-channel interrupt enable gates event flag.
module cacc_channel (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic [15:0]               counter,
    input  wire logic                      counter_tick,
    input  wire logic                      channel_pin_in,
    input  wire cacc_pkg::cacc_bus_req_type bus_req,
    output logic                           channel_pin,
    output logic                           channel_pin_oe,
    output logic                           channel_irq,
    output logic [31:0]                    readdata,
    output logic                           waitrequest
);
    cacc_pkg::cacc_state_type s_r;
    cacc_pkg::cacc_state_type s_nxt;

    // ************************************************************
    // Channel behaviour
    // ************************************************************
    logic        ecom;
    logic        pwm8;
    logic        pwm_enable;
    logic        freq;
    logic        hso;
    logic        swt;
    logic        capt;
    logic        rise;
    logic        fall;
    logic        m16;
    logic        low_wrap;
    logic [10:0] nmask;
    logic        n_match;
    logic        n_ovf;
    logic        wr_low;
    logic        wr_high;
    logic        acc;
    logic [7:0]  half;
    logic        ccf_set;
    logic        cycle_overflow_flag_set;

    always_comb begin
        s_nxt = s_r;
        ecom = s_r.mode[`CACC_BIT_ECOM];
        pwm8 = 1'b0;
        pwm_enable = 1'b0;
        freq = 1'b0;
        hso = 1'b0;
        swt = 1'b0;
        capt = 1'b0;
        ccf_set = 1'b0;
        cycle_overflow_flag_set = 1'b0;
        half = s_r.cc[15:8];
        acc = bus_req.read | bus_req.write;
        wr_low = bus_req.write & (bus_req.address == `CACC_OFS_CC_LOW);
        wr_high = bus_req.write & (bus_req.address == `CACC_OFS_CC_HIGH);
        // Decode of the mode bits with the comparator bit ignored, so the
        // pin goes quiet rather than falling into capture when it is cleared.
        if (s_r.mode[`CACC_BIT_PWM] & ~s_r.mode[`CACC_BIT_TOG]) begin
            if (s_r.cycle_length_sel == `CACC_CL_8) begin
                pwm8 = 1'b1;
            end else begin
                pwm_enable = 1'b1;
            end
        end else if (s_r.mode[`CACC_BIT_PWM] & s_r.mode[`CACC_BIT_TOG]) begin
            freq = 1'b1;
        end else if (s_r.mode[`CACC_BIT_TOG]) begin
            hso = 1'b1;
        end else if (s_r.mode[`CACC_BIT_MAT]) begin
            swt = 1'b1;
        end else begin
            capt = 1'b1;
        end
        case (s_r.cycle_length_sel)
            `CACC_CL_9:  nmask = 11'h1FF;
            `CACC_CL_10: nmask = 11'h3FF;
            `CACC_CL_11: nmask = 11'h7FF;
            default:     nmask = 11'h0FF;
        endcase
        m16 = counter_tick & (counter == s_r.cc);
        low_wrap = counter_tick & (s_r.count_prev[7:0] == `CACC_LOW_ONES)
                   & (counter[7:0] == `CACC_RST_BYTE);
        n_match = counter_tick & ((counter[10:0] & nmask) == (s_r.cc[10:0] & nmask));
        // Overflow out of bit N: low N bits wrapped to zero.
        n_ovf = counter_tick & ((counter[10:0] & nmask) == 11'h000)
                & ((s_r.count_prev[10:0] & nmask) == nmask);
        // Pin synchroniser; only the second stage feeds edge logic.
        s_nxt.pin_s1 = channel_pin_in;
        s_nxt.pin_s2 = s_r.pin_s1;
        s_nxt.pin_prev = s_r.pin_s2;
        rise = s_r.pin_s2 & ~s_r.pin_prev;
        fall = ~s_r.pin_s2 & s_r.pin_prev;
        s_nxt.cnt_tick_s = counter_tick;
        if (counter_tick) begin
            s_nxt.count_prev = counter;
        end
        if (capt & ((rise & s_r.mode[`CACC_BIT_RISE]) | (fall & s_r.mode[`CACC_BIT_FALL]))) begin
            s_nxt.cc = counter;
            ccf_set = 1'b1;
        end
        if (swt & ecom & m16) begin
            ccf_set = 1'b1;
        end
        if (hso & ecom & m16) begin
            s_nxt.pin_out = ~s_r.pin_out;
            ccf_set = s_r.mode[`CACC_BIT_MAT];
        end
        if (freq & ecom) begin
            if (counter_tick & (counter[7:0] == s_r.cc[7:0])) begin
                s_nxt.pin_out = ~s_r.pin_out;
                // Zero wraps naturally: adding 0 returns the same low byte,
                // which next matches after 256 counter clocks.
                s_nxt.cc[7:0] = s_r.cc[7:0] + half;
            end
            if (s_r.mode[`CACC_BIT_MAT] & m16) begin
                ccf_set = 1'b1;
            end
        end
        if (pwm8) begin
            if (low_wrap) begin
                s_nxt.pin_out = 1'b0;
                s_nxt.cc[7:0] = s_r.cc[15:8];
                cycle_overflow_flag_set = 1'b1;
            end else if (ecom & counter_tick & (counter[7:0] == s_r.cc[7:0])) begin
                s_nxt.pin_out = 1'b1;
                ccf_set = s_r.mode[`CACC_BIT_MAT];
            end
            if (~ecom) begin
                s_nxt.pin_out = 1'b0;
            end
        end
        if (pwm_enable) begin
            if (n_ovf) begin
                s_nxt.pin_out = 1'b0;
                cycle_overflow_flag_set = 1'b1;
                s_nxt.cc[10:0] = s_r.reload;
            end else if (ecom & n_match) begin
                s_nxt.pin_out = 1'b1;
                ccf_set = s_r.mode[`CACC_BIT_MAT];
            end
            if (~ecom) begin
                s_nxt.pin_out = 1'b0;
            end
        end

        // ********************************************************
        // Register slave: one-cycle answer, waitrequest low on ack
        // ********************************************************
        s_nxt.ack = acc & ~s_r.ack;
        s_nxt.wreq = ~s_nxt.ack;
        s_nxt.rdata = 32'h0000_0000;
        // A write lands on the edge at which the master sees waitrequest low;
        // a read is latched one edge earlier so its data stands at that edge.
        if (acc) begin
            if (bus_req.write & s_r.ack) begin
                case (bus_req.address)
                    `CACC_OFS_MODE: begin
                        s_nxt.mode = bus_req.writedata[6:0];
                    end
                    `CACC_OFS_CC_LOW: begin
                        if (s_r.reload_reg_select) begin
                            s_nxt.reload[7:0] = bus_req.writedata[7:0];
                        end else begin
                            s_nxt.cc[7:0] = bus_req.writedata[7:0];
                        end
                    end
                    `CACC_OFS_CC_HIGH: begin
                        if (s_r.reload_reg_select) begin
                            s_nxt.reload[10:8] = bus_req.writedata[2:0];
                        end else begin
                            s_nxt.cc[15:8] = bus_req.writedata[7:0];
                        end
                    end
                    `CACC_OFS_PWM_CFG: begin
                        s_nxt.reload_reg_select = bus_req.writedata[`CACC_BIT_RELOAD_REG_SELECT];
                        s_nxt.cycle_length_sel = bus_req.writedata[1:0];
                        if (~bus_req.writedata[`CACC_BIT_CYCLE_OVERFLOW_FLAG]) begin
                            s_nxt.cycle_overflow_flag = 1'b0;
                        end
                    end
                    `CACC_OFS_STATUS: begin
                        if (~bus_req.writedata[`CACC_BIT_CCF]) begin
                            s_nxt.ccf = 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
                if (wr_low) begin
                    s_nxt.mode[`CACC_BIT_ECOM] = 1'b0;
                end
                if (wr_high) begin
                    s_nxt.mode[`CACC_BIT_ECOM] = 1'b1;
                end
            end else if (bus_req.read & ~s_r.ack) begin
                case (bus_req.address)
                    `CACC_OFS_MODE:    s_nxt.rdata = {25'h0, s_r.mode};
                    `CACC_OFS_CC_LOW:  s_nxt.rdata = s_r.reload_reg_select ?
                                                     {24'h0, s_r.reload[7:0]} :
                                                     {24'h0, s_r.cc[7:0]};
                    `CACC_OFS_CC_HIGH: s_nxt.rdata = s_r.reload_reg_select ?
                                                     {29'h0, s_r.reload[10:8]} :
                                                     {24'h0, s_r.cc[15:8]};
                    `CACC_OFS_PWM_CFG: s_nxt.rdata = {24'h0, s_r.reload_reg_select, 1'b0, s_r.cycle_overflow_flag,
                                                      3'h0, s_r.cycle_length_sel};
                    `CACC_OFS_STATUS:  s_nxt.rdata = {30'h0, s_r.pin_s2, s_r.ccf};
                    `CACC_OFS_COUNTER: s_nxt.rdata = {16'h0, counter};
                    default:           s_nxt.rdata = 32'h0000_0000;
                endcase
            end
        end
        // Hardware set wins over a software clear in the same cycle.
        if (ccf_set) begin
            s_nxt.ccf = 1'b1;
        end
        // The overflow flag follows the same rule as the event flag.
        if (cycle_overflow_flag_set) begin
            s_nxt.cycle_overflow_flag = 1'b1;
        end
        s_nxt.irq = s_nxt.ccf & s_nxt.mode[`CACC_BIT_IRQ_EN];
        s_nxt.oe = s_nxt.mode[`CACC_BIT_TOG] | s_nxt.mode[`CACC_BIT_PWM];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
            s_r.wreq <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign channel_pin    = s_r.pin_out;
    assign channel_pin_oe = s_r.oe;
    assign channel_irq    = s_r.irq;
    assign readdata       = s_r.rdata;
    assign waitrequest    = s_r.wreq;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence wr_low_seq;
        bus_req.write && s_r.ack && bus_req.address == `CACC_OFS_CC_LOW;
    endsequence
    sequence wr_high_seq;
        bus_req.write && s_r.ack && bus_req.address == `CACC_OFS_CC_HIGH;
    endsequence

    low_clears_ecom_a: assert property (@(posedge clk) disable iff (rst)
        wr_low_seq |=> !s_r.mode[`CACC_BIT_ECOM])
        else $error("low byte write left comparator on");
    high_sets_ecom_a: assert property (@(posedge clk) disable iff (rst)
        wr_high_seq |=> s_r.mode[`CACC_BIT_ECOM])
        else $error("high byte write left comparator off");
    capture_load_a: assert property (@(posedge clk) disable iff (rst)
        (capt && rise && s_r.mode[`CACC_BIT_RISE]) |=> s_r.cc == $past(counter) && s_r.ccf)
        else $error("capture did not load counter");
    flag_sticky_a: assert property (@(posedge clk) disable iff (rst)
        (s_r.ccf && !(bus_req.write && bus_req.address == `CACC_OFS_STATUS)) |=> s_r.ccf)
        else $error("event flag cleared by hardware");
    irq_gate_a: assert property (@(posedge clk) disable iff (rst)
        channel_irq == (s_r.ccf && s_r.mode[`CACC_BIT_IRQ_EN]))
        else $error("interrupt not gated by enable");
    pwm_off_low_a: assert property (@(posedge clk) disable iff (rst)
        ((pwm8 || pwm_enable) && !ecom && !acc) ##1 (pwm8 || pwm_enable) |-> !channel_pin)
        else $error("pwm output high with comparator off");
    hso_toggle_a: assert property (@(posedge clk) disable iff (rst)
        (hso && ecom && m16) |=> channel_pin != $past(channel_pin))
        else $error("high speed output did not toggle");
    pwm8_reload_a: assert property (@(posedge clk) disable iff (rst)
        (pwm8 && low_wrap && !acc) |=> s_r.cc[7:0] == $past(s_r.cc[15:8]) && s_r.cycle_overflow_flag)
        else $error("eight bit reload missing");
    bus_answer_a: assert property (@(posedge clk) disable iff (rst)
        (acc && waitrequest) |=> !waitrequest)
        else $error("bus answer late");

    // ************************************************************
    // Mode checks
    // ************************************************************
    // Each check leaves out cycles in which a bus write may overwrite
    // the same field, since software wins there by design.
    sequence freq_hit_seq;
        freq && ecom && counter_tick && counter[7:0] == s_r.cc[7:0];
    endsequence

    sequence pwm8_hit_seq;
        pwm8 && ecom && !low_wrap && counter_tick && counter[7:0] == s_r.cc[7:0];
    endsequence

    sequence pwm_enable_ovf_seq;
        pwm_enable && n_ovf && !acc;
    endsequence

    swt_flag_a: assert property (@(posedge clk) disable iff (rst)
        (swt && ecom && m16) |=> s_r.ccf)
        else $error("software timer match did not flag");

    freq_toggle_a: assert property (@(posedge clk) disable iff (rst)
        freq_hit_seq |=> channel_pin != $past(channel_pin))
        else $error("frequency output did not toggle");

    freq_advance_a: assert property (@(posedge clk) disable iff (rst)
        freq_hit_seq ##0 !acc |=>
            s_r.cc[7:0] == 8'($past(s_r.cc[7:0]) + $past(s_r.cc[15:8])))
        else $error("frequency output did not advance");

    freq_match_flag_a: assert property (@(posedge clk) disable iff (rst)
        (freq && ecom && s_r.mode[`CACC_BIT_MAT] && m16) |=> s_r.ccf)
        else $error("frequency full match did not flag");

    hso_hold_a: assert property (@(posedge clk) disable iff (rst)
        (hso && !ecom) |=> channel_pin == $past(channel_pin))
        else $error("high speed output moved with comparator off");

    pwm8_fall_a: assert property (@(posedge clk) disable iff (rst)
        (pwm8 && low_wrap) |=> !channel_pin && s_r.cycle_overflow_flag)
        else $error("eight bit overflow did not fall");

    pwm8_rise_a: assert property (@(posedge clk) disable iff (rst)
        pwm8_hit_seq |=> channel_pin)
        else $error("eight bit match did not rise");

    pwm8_match_flag_a: assert property (@(posedge clk) disable iff (rst)
        pwm8_hit_seq ##0 s_r.mode[`CACC_BIT_MAT] |=> s_r.ccf)
        else $error("eight bit match did not flag");

    pwm_enable_reload_a: assert property (@(posedge clk) disable iff (rst)
        pwm_enable_ovf_seq |=> s_r.cc[10:0] == $past(s_r.reload) && s_r.cycle_overflow_flag && !channel_pin)
        else $error("wide overflow did not reload");

    pwm_enable_rise_a: assert property (@(posedge clk) disable iff (rst)
        (pwm_enable && ecom && n_match && !n_ovf) |=> channel_pin)
        else $error("wide match did not rise");

    capture_fall_a: assert property (@(posedge clk) disable iff (rst)
        (capt && fall && s_r.mode[`CACC_BIT_FALL]) |=> s_r.ccf)
        else $error("falling capture did not flag");

    idle_wait_a: assert property (@(posedge clk) disable iff (rst)
        !acc |=> waitrequest)
        else $error("waitrequest low without request");
endmodule

// File: hw/cacc_consts.svh
`ifndef CACC_CONSTS_SVH
`define CACC_CONSTS_SVH
// Register word offsets on the Avalon-MM slave (word addressed).
`define CACC_OFS_MODE     4'h0
`define CACC_OFS_CC_LOW   4'h1
`define CACC_OFS_CC_HIGH  4'h2
`define CACC_OFS_PWM_CFG  4'h3
`define CACC_OFS_STATUS   4'h4
`define CACC_OFS_COUNTER  4'h5
// Mode register bit positions.
`define CACC_BIT_IRQ_EN   0
`define CACC_BIT_PWM      1
`define CACC_BIT_TOG      2
`define CACC_BIT_MAT      3
`define CACC_BIT_FALL     4
`define CACC_BIT_RISE     5
`define CACC_BIT_ECOM     6
// Pwm config register bit positions.
`define CACC_BIT_RELOAD_REG_SELECT    7
`define CACC_BIT_CYCLE_OVERFLOW_FLAG     5
// Status register bit positions.
`define CACC_BIT_CCF      0
`define CACC_BIT_PIN      1
// Cycle length codes.
`define CACC_CL_8         2'h0
`define CACC_CL_9         2'h1
`define CACC_CL_10        2'h2
`define CACC_CL_11        2'h3
`define CACC_RST_BYTE     8'h00
`define CACC_RST_WORD     16'h0000
`define CACC_LOW_ONES     8'hFF
`endif

// File: hw/cacc_pkg.sv
package cacc_pkg;
    typedef struct packed {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } cacc_bus_req_type;

    typedef struct packed {
        logic [6:0]  mode;
        logic [15:0] cc;
        logic [10:0] reload;
        logic        reload_reg_select;
        logic [1:0]  cycle_length_sel;
        logic        cycle_overflow_flag;
        logic        ccf;
        logic        pin_out;
        logic        pin_s1;
        logic        pin_s2;
        logic        pin_prev;
        logic        cnt_tick_s;
        logic [15:0] count_prev;
        logic        ack;
        logic [31:0] rdata;
        logic        irq;
        logic        oe;
        logic        wreq;
    } cacc_state_type;
endpackage

// File: verification/cacc_channel_tb.sv
`include "cacc_consts.svh"
module cacc_channel_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] a_md = `CACC_OFS_MODE;
    localparam logic [3:0] a_lo = `CACC_OFS_CC_LOW;
    localparam logic [3:0] a_hi = `CACC_OFS_CC_HIGH;
    localparam logic [3:0] a_cf = `CACC_OFS_PWM_CFG;
    localparam logic [3:0] a_st = `CACC_OFS_STATUS;
    logic                       clk, rst, run, counter_tick, level_req, pin_in;
    logic                       channel_pin, channel_pin_oe, channel_irq, waitrequest;
    logic [15:0]                counter, exp_cc;
    logic [31:0]                readdata, rd;
    logic [7:0]                 capm [3];
    cacc_pkg::cacc_bus_req_type bus_req;
    int                         error_cnt, num_checks;
    cacc_channel uut (.clk(clk), .rst(rst), .counter(counter), .counter_tick(counter_tick),
        .channel_pin_in(pin_in), .bus_req(bus_req), .channel_pin(channel_pin),
        .channel_pin_oe(channel_pin_oe), .channel_irq(channel_irq), .readdata(readdata),
        .waitrequest(waitrequest));
    cacc_pin_model src (.clk(clk), .level_req(level_req), .pin(pin_in));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        counter_tick <= run;
        if (run) begin
            counter <= counter + 16'h0001;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // The request stands until an edge samples waitrequest low; data is taken there.
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        bus_req <= '{a, ~w, w, d};
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        bus_req <= '0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rdck(input logic [3:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        chk(rd, e);
    endtask
    task automatic pin_is(input logic e);
        chk({31'h0, channel_pin}, {31'h0, e});
    endtask
    // Counter is stopped one edge before loading so the two writers never meet.
    task automatic load(input logic [15:0] v);
        @(posedge clk);
        run <= 1'b0;
        @(posedge clk);
        counter <= v;
    endtask
    task automatic til(input logic [8:0] v);
        while (counter[8:0] !== v) begin
            @(posedge clk);
        end
    endtask
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end
    // ****
    // Stimulus and checks.
    // ****
    initial begin
        logic hi;
        rst = 1'b1;
        run = 1'b0;
        counter = 16'h0000;
        counter_tick = 1'b0;
        level_req = 1'b0;
        bus_req = '0;
        error_cnt = 0;
        num_checks = 0;
        exp_cc = 16'h0000;
        capm = '{8'h20, 8'h10, 8'h30};
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rdck(a_md, 32'h0);
        rdck(a_cf, 32'h0);
        wr(4'hF, 32'hFFFFFFFF);
        rdck(4'hF, 32'h0);
        $display("Test reset done");
        for (int i = 0; i < 3; i++) begin
            wr(a_md, {24'h0, capm[i]});
            wr(a_st, 32'h0);
            for (int e = 0; e < 2; e++) begin
                load(16'hA000 + 16'(i * 2 + e));
                level_req <= (e == 0);
                repeat (8) @(posedge clk);
                if (capm[i][5 - e]) begin
                    exp_cc = counter;
                end
                rdck(a_lo, {24'h0, exp_cc[7:0]});
                rdck(a_hi, {24'h0, exp_cc[15:8]});
            end
            rdck(a_st, 32'h1);
        end
        wr(a_md, 32'h31);
        level_req <= 1'b1;
        repeat (8) @(posedge clk);
        pin_is(1'b0);
        chk({31'h0, channel_pin_oe}, 32'h0);
        chk({31'h0, channel_irq}, 32'h1);
        rdck(a_st, 32'h3);
        wr(a_st, 32'h0);
        repeat (2) @(posedge clk);
        chk({31'h0, channel_irq}, 32'h0);
        level_req <= 1'b0;
        $display("Test capture done");
        wr(a_md, 32'h48);
        wr(a_lo, 32'h10);
        rdck(a_md, 32'h08);
        wr(a_hi, 32'h20);
        rdck(a_md, 32'h48);
        wr(a_st, 32'h0);
        load(16'h1FF0);
        run <= 1'b1;
        repeat (8) @(posedge clk);
        rdck(a_st, 32'h0);
        repeat (40) @(posedge clk);
        rdck(a_st, 32'h1);
        wr(a_md, 32'h4C);
        load(16'h2000);
        run <= 1'b1;
        repeat (40) @(posedge clk);
        pin_is(1'b1);
        chk({31'h0, channel_pin_oe}, 32'h1);
        wr(a_lo, 32'h10);
        load(16'h2000);
        run <= 1'b1;
        repeat (40) @(posedge clk);
        pin_is(1'b1);
        $display("Test compare done");
        load(16'h0000);
        wr(a_cf, 32'h0);
        wr(a_md, 32'h0A);
        wr(a_lo, 32'h80);
        wr(a_hi, 32'h80);
        wr(a_st, 32'h0);
        run <= 1'b1;
        til(9'h040);
        pin_is(1'b0);
        til(9'h0C0);
        pin_is(1'b1);
        rdck(a_st, 32'h1);
        wr(a_hi, 32'hC0);
        til(9'h110);
        pin_is(1'b0);
        rdck(a_cf, 32'h20);
        rdck(a_lo, 32'hC0);
        til(9'h1A0);
        pin_is(1'b0);
        wr(a_md, 32'h02);
        hi = 1'b0;
        repeat (300) begin
            @(posedge clk);
            hi = hi | channel_pin;
        end
        chk({31'h0, hi}, 32'h0);
        $display("Test pwm8 done");
        load(16'h0000);
        wr(a_cf, 32'h81);
        wr(a_lo, 32'h00);
        wr(a_hi, 32'h01);
        rdck(a_hi, 32'h01);
        wr(a_cf, 32'h01);
        wr(a_lo, 32'hC0);
        wr(a_hi, 32'h00);
        run <= 1'b1;
        til(9'h080);
        pin_is(1'b0);
        til(9'h180);
        pin_is(1'b1);
        til(9'h010);
        pin_is(1'b0);
        rdck(a_cf, 32'h21);
        rdck(a_hi, 32'h01);
        til(9'h0C8);
        pin_is(1'b0);
        til(9'h140);
        pin_is(1'b1);
        $display("Test pwm9 done");
        give_verdict();
    end
endmodule

// File: verification/cacc_pin_model.sv
// ****
// External signal source on the channel pin.
// ****
module cacc_pin_model (
    input  wire logic clk,
    input  wire logic level_req,
    output logic      pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] held_r;
    initial pin = 1'b0;
    initial held_r = 2'h0;
    // A new level is shown only once the old one stood two clocks, so no edge is lost.
    always @(posedge clk) begin
        if (pin != level_req && held_r >= 2'h2) begin
            pin <= level_req;
            held_r <= 2'h1;
        end else if (held_r != 2'h3) begin
            held_r <= held_r + 2'h1;
        end
    end
endmodule
